// File: verilog/mcad_pkg.sv
// Package of constants and types for the memory controller address decoder
`default_nettype none
package mcad_pkg;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [31:0] MCAD_INT_MEM_TOP   = 32'h0040_0000;
  localparam logic [31:0] MCAD_PERIPH_BASE   = 32'hFFC0_0000;
  localparam logic [31:0] MCAD_VECTOR_TOP    = 32'h0000_0020;
  localparam int          MCAD_SRAM_WORDS    = 2048;
  localparam int          MCAD_SRAM_AW       = 11;
  localparam int          MCAD_PERIPH_SHIFT  = 14;
  localparam int          MCAD_INTC_SHIFT    = 12;
  localparam logic [7:0]  MCAD_INTC_SLOT     = 8'hFF;
  localparam int          MCAD_BANKS         = 8;
  localparam logic [31:0] MCAD_BANK_SIZE_MIN = 32'h0010_0000;
  localparam int          MCAD_BANK_SIZE_SEL_MAX = 4;
  localparam logic [3:0]  MCAD_STRAP_CYCLES  = 4'hA;
  // ----------------------------------------
  // Access sizes and types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MCAD_SZ_BYTE = 2'b00,
    MCAD_SZ_HALF = 2'b01,
    MCAD_SZ_WORD = 2'b10
  } mcad_size_t;
  typedef enum logic [1:0] {
    MCAD_RGN_INT    = 2'b00,
    MCAD_RGN_EXT    = 2'b01,
    MCAD_RGN_PERIPH = 2'b10
  } mcad_region_t;
  localparam logic [2:0] MCAD_ABT_NONE      = 3'h0;
  localparam logic [2:0] MCAD_ABT_UNDEF     = 3'h1;
  localparam logic [2:0] MCAD_ABT_WPROT     = 3'h2;
  localparam logic [2:0] MCAD_ABT_MISALIGN  = 3'h4;
endpackage : mcad_pkg
`default_nettype wire

// File: verilog/mcad_sram.sv
// Internal 32-bit single-cycle SRAM with byte writes
`default_nettype none
module mcad_sram
  import mcad_pkg::*;
#(
  parameter int AW = MCAD_SRAM_AW
) (
  input  wire logic          clk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [3:0]    be,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  output var  logic [31:0]   rdata
);
  logic [31:0] rd_word;
  // ----------------------------------------
  // Byte lanes, little-endian
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      // One array per lane keeps every store owned by a single process
      logic [7:0] lane_mem [0:(1<<AW)-1];
      always_ff @(posedge clk) begin
        if (en && we && be[gi]) begin
          lane_mem[addr] <= wdata[gi*8 +: 8];
        end
      end
      assign rd_word[gi*8 +: 8] = lane_mem[addr];
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (en) begin
      rdata <= rd_word;
    end
  end
endmodule : mcad_sram
`default_nettype wire

// File: verilog/mcad_decode.sv
// Memory controller address decode, remap, boot strap and abort logic
`default_nettype none
module mcad_decode
  import mcad_pkg::*;
#(
  parameter int BANKS = MCAD_BANKS
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        external_reset_pin_n,
  input  wire logic        internal_reset,
  input  wire logic        boot_width_strap,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [1:0]  size,
  input  wire logic        fetch,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        remap_command_bit,
  input  wire logic        periph_mode_ok,
  input  wire logic [7:0]  bank_enable,
  input  wire logic [7:0]  bank_wprot,
  input  wire logic [23:0] bank_base_mb,
  input  wire logic [1:0]  bank_size_sel,
  input  wire logic [23:0] bank_waits,
  input  wire logic [15:0] bank_float,
  input  wire logic [7:0]  bank_wide,
  input  wire logic [7:0]  bank_byte_write,
  input  wire logic        early_read,
  input  wire logic        abort_clear,
  output var  logic [31:0] rdata,
  output var  logic        rvalid,
  output var  logic        abort,
  output var  logic        abort_prefetch,
  output var  logic        remap_done,
  output var  logic        boot_8bit,
  output var  logic [2:0]  abort_status,
  output var  logic [31:0] abort_addr,
  output var  logic        abort_was_fetch,
  output var  logic        abort_was_write,
  output var  logic        ext_req,
  output var  logic [7:0]  ext_cs,
  output var  logic [31:0] ext_addr,
  output var  logic [31:0] ext_wdata,
  output var  logic        ext_we,
  output var  logic [3:0]  ext_lane,
  output var  logic        ext_lane_is_write,
  output var  logic [2:0]  ext_waits,
  output var  logic [1:0]  ext_float,
  output var  logic        ext_wide,
  output var  logic        ext_early_read,
  input  wire logic [31:0] ext_rdata,
  output var  logic        per_req,
  output var  logic        per_we,
  output var  logic [31:0] per_addr,
  output var  logic [5:0]  per_slot,
  output var  logic        per_intc,
  output var  logic [31:0] per_wdata,
  input  wire logic [31:0] per_rdata
);
  // ----------------------------------------
  // Reset handling and boot strap
  // ----------------------------------------
  logic       any_rst;
  logic       boot_8bit_reg;
  logic       pin_rst_d_reg;
  logic       remap_reg;
  assign any_rst = !rstn || !external_reset_pin_n || internal_reset;
  // Strap window: last ten cycles before pin release; majority limits glitches
  logic [MCAD_STRAP_CYCLES-1:0] strap_hist_reg;
  always_ff @(posedge clk) begin
    if (!external_reset_pin_n) begin
      strap_hist_reg <= {strap_hist_reg[MCAD_STRAP_CYCLES-2:0], boot_width_strap};
    end
  end
  logic strap_vote;
  assign strap_vote = ($countones(strap_hist_reg) > (MCAD_STRAP_CYCLES / 2));
  always_ff @(posedge clk) begin
    pin_rst_d_reg <= external_reset_pin_n;
    if (!rstn) begin
      boot_8bit_reg <= 1'b0;
    end else if (external_reset_pin_n && !pin_rst_d_reg) begin
      boot_8bit_reg <= strap_vote;
    end
  end
  always_ff @(posedge clk) begin
    if (any_rst) begin
      remap_reg <= 1'b0;
    end else if (remap_command_bit) begin
      remap_reg <= 1'b1;
    end
  end
  assign remap_done = remap_reg;
  assign boot_8bit  = boot_8bit_reg;
  // ----------------------------------------
  // Region decode
  // ----------------------------------------
  logic in_int;
  logic in_per;
  logic in_ext;
  logic misalign;
  assign in_int = (addr < MCAD_INT_MEM_TOP);
  assign in_per = (addr >= MCAD_PERIPH_BASE);
  assign in_ext = !in_int && !in_per;
  assign misalign = ((size == MCAD_SZ_HALF) && addr[0]) || ((size == MCAD_SZ_WORD) && (addr[1:0] != 2'b00));
  // Byte enables, little-endian lanes
  logic [3:0] be;
  assign be = (size == MCAD_SZ_BYTE) ? (4'h1 << addr[1:0]) :
              (size == MCAD_SZ_HALF) ? (addr[1] ? 4'hC : 4'h3) : 4'hF;
  // Before remap the low region is boot memory on chip select zero
  logic sram_hit;
  logic boot_hit;
  assign sram_hit = in_int && remap_reg;
  assign boot_hit = in_int && !remap_reg;
  // ----------------------------------------
  // External bank match
  // ----------------------------------------
  logic [31:0] bank_mask;
  assign bank_mask = ~((MCAD_BANK_SIZE_MIN << (bank_size_sel * MCAD_BANK_SIZE_SEL_MAX)) - 32'h1);
  // Match on the offset into the region, since 16 MB banks are not aligned to its base
  logic [31:0] ext_off;
  assign ext_off = addr - MCAD_INT_MEM_TOP;
  logic [7:0] bank_hit;
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      // Bank count halves above 1 MB: only banks 0 to 3 can match when bank_size_sel is not zero
      logic        allowed;
      logic [31:0] base_addr;
      assign allowed = bank_enable[gb] && ((bank_size_sel == 2'b00) || (gb < 4)) && (remap_reg || gb == 0);
      assign base_addr = {9'h000, bank_base_mb[gb*3 +: 3], 20'h0_0000} << (bank_size_sel * MCAD_BANK_SIZE_SEL_MAX);
      assign bank_hit[gb] = allowed && in_ext &&
        ((ext_off & bank_mask) == base_addr);
    end
  endgenerate
  logic [2:0] bank_idx;
  always_comb begin
    bank_idx = 3'h0;
    for (int i = BANKS - 1; i >= 0; i--) begin
      if (bank_hit[i]) begin
        bank_idx = 3'(i);
      end
    end
  end
  logic ext_any;
  logic undef_ext;
  logic wprot_hit;
  assign ext_any   = (|bank_hit) || boot_hit;
  assign undef_ext = in_ext && !(|bank_hit);
  assign wprot_hit = in_ext && (|bank_hit) && we && bank_wprot[bank_idx];
  // ----------------------------------------
  // Abort decision
  // ----------------------------------------
  logic abort_now;
  logic cancel_now;
  logic [2:0] abort_kind;
  assign abort_kind = req ? ({misalign && !in_per, wprot_hit, undef_ext}) : MCAD_ABT_NONE;
  assign abort_now  = |abort_kind;
  assign cancel_now = req && (undef_ext || wprot_hit);
  // ----------------------------------------
  // SRAM port
  // ----------------------------------------
  logic [31:0] sram_rdata;
  logic [31:0] wdata_lane;
  assign wdata_lane = (size == MCAD_SZ_BYTE) ? {4{wdata[7:0]}} :
                      (size == MCAD_SZ_HALF) ? {2{wdata[15:0]}} : wdata;
  mcad_sram #(.AW(MCAD_SRAM_AW)) u_sram (
    .clk   (clk),
    .en    (req && sram_hit),
    .we    (we),
    .be    (be),
    .addr  (addr[MCAD_SRAM_AW+1:2]),
    .wdata (wdata_lane),
    .rdata (sram_rdata)
  );
  // ----------------------------------------
  // Request routing, registered outputs
  // ----------------------------------------
  mcad_region_t rgn_reg;
  always_ff @(posedge clk) begin
    if (any_rst) begin
      rvalid            <= 1'b0;
      abort             <= 1'b0;
      abort_prefetch    <= 1'b0;
      ext_req           <= 1'b0;
      ext_cs            <= 8'h00;
      ext_addr          <= 32'h0000_0000;
      ext_wdata         <= 32'h0000_0000;
      ext_we            <= 1'b0;
      ext_lane          <= 4'h0;
      ext_lane_is_write <= 1'b0;
      ext_waits         <= 3'h0;
      ext_float         <= 2'h0;
      ext_wide          <= 1'b0;
      ext_early_read    <= 1'b0;
      per_req           <= 1'b0;
      per_we            <= 1'b0;
      per_addr          <= 32'h0000_0000;
      per_slot          <= 6'h00;
      per_intc          <= 1'b0;
      per_wdata         <= 32'h0000_0000;
      rgn_reg           <= MCAD_RGN_INT;
    end else begin
      rvalid         <= req && !we;
      abort          <= abort_now;
      abort_prefetch <= abort_now && fetch;
      ext_req        <= req && ext_any && (in_ext || boot_hit) && !cancel_now;
      ext_cs         <= boot_hit ? 8'h01 : bank_hit;
      ext_addr       <= addr;
      ext_wdata      <= wdata_lane;
      ext_we         <= we;
      ext_lane       <= be;
      ext_lane_is_write <= boot_hit ? 1'b0 : (bank_wide[bank_idx] && bank_byte_write[bank_idx]);
      ext_waits      <= bank_waits[bank_idx*3 +: 3];
      ext_float      <= bank_float[bank_idx*2 +: 2];
      ext_wide       <= boot_hit ? !boot_8bit_reg : bank_wide[bank_idx];
      ext_early_read <= early_read;
      per_req        <= req && in_per;
      per_we         <= req && in_per && we && periph_mode_ok;
      per_addr       <= {addr[31:2], 2'b00};
      per_slot       <= addr[MCAD_PERIPH_SHIFT +: 6];
      per_intc       <= (addr[MCAD_PERIPH_SHIFT +: 8] == MCAD_INTC_SLOT);
      per_wdata      <= wdata;
      rgn_reg        <= in_int ? MCAD_RGN_INT : (in_per ? MCAD_RGN_PERIPH : MCAD_RGN_EXT);
    end
  end
  assign rdata = (rgn_reg == MCAD_RGN_PERIPH) ? per_rdata :
                 ((rgn_reg == MCAD_RGN_INT) && remap_reg) ? sram_rdata : ext_rdata;
  // ----------------------------------------
  // Abort record
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (any_rst) begin
      abort_status    <= MCAD_ABT_NONE;
      abort_addr      <= 32'h0000_0000;
      abort_was_fetch <= 1'b0;
      abort_was_write <= 1'b0;
    end else if (abort_now) begin
      // A new abort beats a clear in the same cycle
      abort_status    <= abort_kind;
      abort_addr      <= addr;
      abort_was_fetch <= fetch;
      abort_was_write <= we;
    end else if (abort_clear) begin
      abort_status    <= MCAD_ABT_NONE;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_abort_periph;
    @(posedge clk) disable iff (!rstn) (req && in_per) |=> !abort;
  endproperty
  a_no_abort_periph: assert property (p_no_abort_periph) else $error("abort on peripheral");
  property p_wprot_cancel;
    @(posedge clk) disable iff (any_rst) (req && wprot_hit) |=> (abort && !ext_req);
  endproperty
  a_wprot_cancel: assert property (p_wprot_cancel) else $error("protected write not cancelled");
  property p_misalign_go;
    @(posedge clk) disable iff (any_rst) (req && misalign && in_ext && (|bank_hit) && !wprot_hit) |=> (abort && ext_req);
  endproperty
  a_misalign_go: assert property (p_misalign_go) else $error("misaligned access cancelled");
  property p_remap_sticky;
    @(posedge clk) disable iff (any_rst) remap_reg |=> remap_reg;
  endproperty
  a_remap_sticky: assert property (p_remap_sticky) else $error("remap cleared");
  property p_cs_high_needs_remap;
    @(posedge clk) disable iff (any_rst) (ext_req && (|ext_cs[7:1])) |-> $past(remap_reg);
  endproperty
  a_cs_high_needs_remap: assert property (p_cs_high_needs_remap) else $error("high select before remap");
  property p_undef_abort;
    @(posedge clk) disable iff (any_rst) (req && undef_ext) |=> (abort && !ext_req);
  endproperty
  a_undef_abort: assert property (p_undef_abort) else $error("undefined external not aborted");
  property p_per_word;
    @(posedge clk) disable iff (any_rst) per_req |-> (per_addr == {$past(addr[31:2]), 2'b00});
  endproperty
  a_per_word: assert property (p_per_word) else $error("peripheral address not word");
  property p_mode_drop;
    @(posedge clk) disable iff (any_rst) (req && in_per && we && !periph_mode_ok) |=> (!per_we && !abort);
  endproperty
  a_mode_drop: assert property (p_mode_drop) else $error("protected write passed");
  property p_record;
    @(posedge clk) disable iff (any_rst) abort_now |=> (abort_addr == $past(addr) && abort_status != MCAD_ABT_NONE);
  endproperty
  a_record: assert property (p_record) else $error("abort not recorded");
  sequence s_strap_ones;
    (!external_reset_pin_n && boot_width_strap) [*8];
  endsequence
  sequence s_strap_zeros;
    (!external_reset_pin_n && !boot_width_strap) [*8];
  endsequence
  sequence s_boot_req;
    req && in_int && !remap_reg;
  endsequence
  property p_strap_one;
    @(posedge clk) disable iff (!rstn) (s_strap_ones ##1 external_reset_pin_n) |=> boot_8bit;
  endproperty
  a_strap_one: assert property (p_strap_one) else $error("high strap not latched");
  property p_strap_zero;
    @(posedge clk) disable iff (!rstn) (s_strap_zeros ##1 external_reset_pin_n) |=> !boot_8bit;
  endproperty
  a_strap_zero: assert property (p_strap_zero) else $error("low strap not latched");
  property p_boot_cs0;
    @(posedge clk) disable iff (any_rst) s_boot_req |=> (ext_req && ext_cs == 8'h01 && ext_wide == !boot_8bit);
  endproperty
  a_boot_cs0: assert property (p_boot_cs0) else $error("boot access not on select zero");
  property p_keep_boot;
    @(posedge clk) disable iff (!rstn) (internal_reset && external_reset_pin_n && pin_rst_d_reg) |=> $stable(boot_8bit);
  endproperty
  a_keep_boot: assert property (p_keep_boot) else $error("internal reset changed boot width");
  property p_remap_set;
    @(posedge clk) disable iff (any_rst) remap_command_bit |=> remap_reg;
  endproperty
  a_remap_set: assert property (p_remap_set) else $error("remap command ignored");
  property p_int_read;
    @(posedge clk) disable iff (any_rst) (req && in_int && !we && !misalign) |=> (!abort && rvalid);
  endproperty
  a_int_read: assert property (p_int_read) else $error("internal read aborted");
endmodule : mcad_decode
`default_nettype wire

// File: testbench/mcad_far_model.sv
// Far-side model: external devices and peripheral bus returning read data
`default_nettype none
module mcad_far_model (
  input  wire logic        clk,
  input  wire logic        ext_req,
  input  wire logic [31:0] ext_addr,
  input  wire logic        per_req,
  input  wire logic [31:0] per_addr,
  output var  logic [31:0] ext_rdata,
  output var  logic [31:0] per_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] junk_reg = 32'h0F0F_3C3C;
  // Released bus toggles every cycle so a stale word never passes for data
  always_ff @(posedge clk) junk_reg <= ~junk_reg;
  assign ext_rdata = ext_req ? (ext_addr ^ 32'hA5A5_5A5A) : junk_reg;
  assign per_rdata = per_req ? ~per_addr : junk_reg;
endmodule : mcad_far_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the memory controller address decoder
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import mcad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'h0, rstn = 1'h0, external_reset_pin_n = 1'h0, internal_reset = 1'h0;
  logic boot_width_strap = 1'h1, req = 1'h0, we = 1'h0, fetch = 1'h0, remap_command_bit = 1'h0;
  logic periph_mode_ok = 1'h1, early_read = 1'h0, abort_clear = 1'h0;
  logic [1:0] size = 2'h0, bank_size_sel = 2'h0;
  logic [31:0] addr = 32'h0, wdata = 32'h0;
  logic [7:0] bank_enable = 8'hFF, bank_wprot = 8'h04, bank_wide = 8'h0, bank_byte_write = 8'h0;
  logic [23:0] bank_base_mb = 24'hFA_C688, bank_waits = 24'h0;
  logic [15:0] bank_float = 16'h0;
  logic [31:0] rdata, abort_addr, ext_addr, ext_wdata, ext_rdata, per_addr, per_wdata, per_rdata;
  logic rvalid, abort, abort_prefetch, remap_done, boot_8bit, abort_was_fetch, abort_was_write;
  logic ext_req, ext_we, ext_lane_is_write, ext_wide, ext_early_read, per_req, per_we, per_intc;
  logic [2:0] abort_status, ext_waits;
  logic [7:0] ext_cs;
  logic [3:0] ext_lane;
  logic [1:0] ext_float;
  logic [5:0] per_slot;
  int failures = 0, samples_checked = 0, cycles = 0;
  logic [31:0] seed = 32'h0000_F4A3;
  mcad_decode u_mcad_decode (.*);
  mcad_far_model u_mcad_far_model (.*);
  always #50 clk = ~clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [3:0] lane_of(input logic [31:0] a, input logic [1:0] s);
    return s == MCAD_SZ_WORD ? 4'hF : s == MCAD_SZ_HALF ? 4'h3 << {a[1], 1'h0} : 4'h1 << a[1:0];
  endfunction : lane_of
  task automatic print_verdict();
    $display("Checked %0d values, %0d mismatches", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s, input logic f,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    we <= w;
    size <= s;
    fetch <= f;
    wdata <= d;
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    #1;
  endtask : acc
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: remap_command_bit <= 1'h1;
      1: abort_clear <= 1'h1;
      default: internal_reset <= 1'h1;
    endcase
    @(posedge clk);
    remap_command_bit <= 1'h0;
    abort_clear <= 1'h0;
    internal_reset <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse
  task automatic pin_reset(input logic s);
    @(posedge clk);
    external_reset_pin_n <= 1'h0;
    boot_width_strap <= s;
    repeat (12) @(posedge clk);
    external_reset_pin_n <= 1'h1;
    // Strap line is reused once out of reset, so flip it to prove the latch
    boot_width_strap <= ~s;
    repeat (2) @(posedge clk);
    #1;
    `CHK(boot_8bit, s)
    `CHK(remap_done, 1'h0)
  endtask : pin_reset
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] a, d, m;
    logic [1:0] s;
    int b;
    repeat (5) @(posedge clk);
    #1;
    `CHK(remap_done, 1'h0)
    rstn <= 1'h1;
    pin_reset(1'h1);
    acc(32'h0, 1'h0, MCAD_SZ_WORD, 1'h1, 32'h0);
    `CHK(ext_cs, 8'h01)
    `CHK(ext_wide, 1'h0)
    acc(32'h0050_0000, 1'h0, MCAD_SZ_WORD, 1'h0, 32'h0);
    `CHK({abort, ext_req}, 2'h2)
    pulse(0);
    `CHK(remap_done, 1'h1)
    acc(32'h10, 1'h1, MCAD_SZ_WORD, 1'h0, 32'h1234_5678);
    acc(32'h11, 1'h1, MCAD_SZ_BYTE, 1'h0, 32'hABAB_ABAB);
    acc(32'h10, 1'h0, MCAD_SZ_WORD, 1'h0, 32'h0);
    `CHK(rdata, 32'h1234_AB78)
    `CHK({rvalid, abort, ext_req}, 3'h4)
    acc(32'h0030_0000, 1'h0, MCAD_SZ_WORD, 1'h0, 32'h0);
    `CHK(abort, 1'h0)
    acc(32'h0060_0000, 1'h1, MCAD_SZ_WORD, 1'h0, 32'h5);
    `CHK({abort, ext_req, abort_was_write}, 3'h5)
    `CHK(abort_status, MCAD_ABT_WPROT)
    acc(32'h00C0_0000, 1'h0, MCAD_SZ_WORD, 1'h1, 32'h0);
    `CHK({abort, abort_prefetch, ext_req, abort_was_fetch}, 4'hD)
    `CHK({abort_status, abort_addr}, {MCAD_ABT_UNDEF, 32'h00C0_0000})
    for (int w = 0; w < 2; w++) begin
      acc(32'h0050_0002, w[0], MCAD_SZ_WORD, 1'h0, 32'h9);
      `CHK({abort, ext_req, ext_we}, {2'h3, w[0]})
      `CHK(abort_status, MCAD_ABT_MISALIGN)
    end
    pulse(1);
    `CHK(abort_status, MCAD_ABT_NONE)
    periph_mode_ok <= 1'h0;
    acc(32'hFFC0_4003, 1'h1, MCAD_SZ_BYTE, 1'h0, 32'h7);
    `CHK({per_req, per_we, abort}, 3'h4)
    periph_mode_ok <= 1'h1;
    acc(32'hFFC0_8004, 1'h1, MCAD_SZ_WORD, 1'h0, 32'h0000_BEEF);
    `CHK({per_req, per_we, per_wdata}, {2'h3, 32'h0000_BEEF})
    acc(32'h0070_0001, 1'h1, MCAD_SZ_BYTE, 1'h0, 32'h0000_00C3);
    `CHK({ext_req, abort, ext_lane, ext_wdata}, {2'h2, 4'h2, 32'hC3C3_C3C3})
    d = rnd();
    bank_waits <= d[23:0];
    bank_float <= d[31:16];
    d = rnd();
    bank_wide <= d[7:0];
    bank_byte_write <= d[15:8];
    early_read <= d[16];
    for (int i = 0; i < 60; i++) begin
      d = rnd();
      if (d[1:0] == 2'h0) begin
        a = {19'h0, d[12:2], 2'h0};
        m = rnd();
        acc(a, 1'h1, MCAD_SZ_WORD, 1'h0, m);
        acc(a, 1'h0, MCAD_SZ_WORD, 1'h0, 32'h0);
        `CHK({rvalid, rdata}, {1'h1, m})
      end else if (d[1:0] == 2'h1) begin
        a = {10'h3FF, d[23:2]};
        acc(a, 1'h0, MCAD_SZ_BYTE, 1'h0, 32'h0);
        `CHK({per_addr, rdata}, {a[31:2], 2'h0, ~a[31:2], 2'h3})
        `CHK({per_slot, per_intc}, {a[19:14], a[21:14] == 8'hFF})
        `CHK(abort, 1'h0)
      end else begin
        // Bank 2 is write-protected, so reads keep to banks 1 and 3 to 7
        b = d[4:2] < 3 ? 1 : int'(d[4:2]);
        s = d[6:5] == 2'h3 ? MCAD_SZ_WORD : d[6:5];
        m = {12'h0, d[26:7]};
        m[0] = m[0] & (s == MCAD_SZ_BYTE);
        m[1] = m[1] & (s != MCAD_SZ_WORD);
        a = 32'h0040_0000 + (32'(b) << 20) + m;
        acc(a, 1'h0, s, 1'h0, 32'h0);
        `CHK({ext_req, abort, rdata}, {2'h2, a ^ 32'hA5A5_5A5A})
        `CHK(ext_cs, 8'h01 << b)
        `CHK(ext_lane, lane_of(a, s))
        `CHK({ext_waits, ext_float, ext_wide}, {bank_waits[3*b+:3], bank_float[2*b+:2], bank_wide[b]})
        `CHK(ext_lane_is_write, bank_wide[b] & bank_byte_write[b])
        `CHK(ext_early_read, early_read)
      end
    end
    bank_size_sel <= 2'h1;
    acc(32'h0350_0000, 1'h0, MCAD_SZ_WORD, 1'h0, 32'h0);
    `CHK({ext_req, abort, ext_cs}, {2'h2, 8'h08})
    acc(32'h0540_0000, 1'h0, MCAD_SZ_WORD, 1'h0, 32'h0);
    `CHK({ext_req, abort}, 2'h1)
    bank_size_sel <= 2'h0;
    pulse(2);
    `CHK({remap_done, boot_8bit}, 2'h1)
    pin_reset(1'h0);
    acc(32'h4, 1'h0, MCAD_SZ_WORD, 1'h1, 32'h0);
    `CHK({ext_cs, ext_wide}, {8'h01, 1'h1})
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
